// >>> rtl/port_pkg.sv
package port_pkg;

    localparam int          PIN_COUNT = 8;
    localparam int          OE_COUNT  = 4;
    localparam int          PAIR_COUNT = 4;

    // Register byte addresses.
    localparam logic [11:0] ADDR_INT_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_INT_MASK    = 12'h004;
    localparam logic [11:0] ADDR_EDGE_MODE   = 12'h008;
    localparam logic [11:0] ADDR_PORT_CFG    = 12'h00c;
    localparam logic [11:0] ADDR_IN_SYNC     = 12'h010;
    localparam logic [11:0] ADDR_OUT_PIPE    = 12'h014;
    localparam logic [11:0] ADDR_INBUF_DIS   = 12'h018;
    localparam logic [11:0] ADDR_SPECIAL_CFG = 12'h01c;
    localparam logic [11:0] ADDR_PIN_STATE   = 12'h020;
    localparam logic [11:0] ADDR_DRIVE_MODE  = 12'h024;
    localparam logic [11:0] ADDR_PIN_STATUS  = 12'h028;

    // Edge mode per pin, two bits each.
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_BOTH    = 2'h3
    } edge_mode_t;

    // Input threshold per port.
    localparam logic THRESH_CMOS  = 1'b0;
    localparam logic THRESH_LVTTL = 1'b1;

    // Special pin pair reference selector codes.
    typedef enum logic [1:0] {
        REF_HALF_SUPPLY  = 2'h0,
        REF_40PCT_SUPPLY = 2'h1,
        REF_HALF_VREF    = 2'h2,
        REF_FULL_VREF    = 2'h3
    } ref_sel_t;

    // Drive modes, three bits per pin.
    localparam logic [2:0] DRIVE_PULL_UP   = 3'h2;
    localparam logic [2:0] DRIVE_PULL_DOWN = 3'h3;
    localparam logic [2:0] DRIVE_STRONG    = 3'h6;

    // Output enable grouping modes.
    typedef enum logic [1:0] {
        OE_GANG_ALL = 2'h0,
        OE_GANG_TWO = 2'h1,
        OE_GANG_FOUR = 2'h2
    } oe_group_t;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] RESET_SYNC = 32'h0000_00ff;

endpackage : port_pkg

// >>> rtl/pin_edge_detect.sv
`timescale 1ns/1ps
module pin_edge_detect
    import port_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Pin sample and mode
    input  wire logic       level,
    input  wire edge_mode_t mode,
    // Event
    output logic            event_q
);

    logic prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    // Only edges are seen; a steady level never repeats an event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_q <= 1'b0;
        end else begin
            case (mode)
                EDGE_RISING:  event_q <= level & ~prev_q;
                EDGE_FALLING: event_q <= ~level & prev_q;
                EDGE_BOTH:    event_q <= level ^ prev_q;
                default:      event_q <= 1'b0;
            endcase
        end
    end

endmodule : pin_edge_detect

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Data
    input  wire logic d,
    output logic      q
);

    logic meta_q;

    // The first stage is read by the second stage only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : pin_sync

// >>> rtl/port_pin_interrupt_and_sync.sv
// Behaviour
// - Each pin: rising, falling, both or none
// - Matching edge sets status flag, raises request
// - One request per port, flags identify pin
// - Edge detection keeps running during sleep
// - Edge detection only, no level mode
// - One threshold select per port, CMOS/LVTTL
// - Each pin input buffer separately disableable
// - Special pin selects supply or regulated high
// - No resistive pulls in regulated mode; here drive_mode can still show a pull for one cycle
// - Pair reference selects one of four thresholds
// - Twenty fabric routes: sixteen data, four drive
// - Input, output, enable make bidirectional pin
// - Output path optionally registered per signal
// - Input path optionally double synchronised
// - Fabric data signals usable as requests
// - Output enables grouped one to four signals
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module port_pin_interrupt_and_sync
    import port_pkg::*;
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    // Fabric side
    input  wire logic [7:0]  fabric_out,
    input  wire logic [3:0]  fabric_oe,
    output logic      [7:0]  fabric_in,
    output logic      [7:0]  fabric_req,
    // Analogue pad controls
    output logic             lvttl_sel,
    output logic      [7:0]  inbuf_en,
    output logic      [7:0]  regulated_sel,
    output logic      [7:0]  ref_sel,
    output logic      [23:0] drive_mode,
    // Interrupt
    output logic             port_irq
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  status_q;
    logic [7:0]  mask_q;
    logic [15:0] edge_q;
    logic [2:0]  port_cfg_q;
    logic [7:0]  in_sync_q;
    logic [7:0]  out_pipe_q;
    logic [7:0]  inbuf_dis_q;
    logic [15:0] special_q;
    logic [23:0] drive_q;
    logic [7:0]  sync_pin;
    logic [7:0]  in_sel;
    logic [7:0]  pin_event;
    logic [7:0]  out_reg_q;
    logic [7:0]  oe_vec;
    logic [7:0]  out_sel;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    oe_group_t   oe_group;

    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign oe_group = oe_group_t'(port_cfg_q[2:1]);

    always_comb begin
        case (paddr)
            ADDR_INT_STATUS, ADDR_INT_MASK, ADDR_EDGE_MODE, ADDR_PORT_CFG,
            ADDR_IN_SYNC, ADDR_OUT_PIPE, ADDR_INBUF_DIS, ADDR_SPECIAL_CFG,
            ADDR_PIN_STATE, ADDR_DRIVE_MODE, ADDR_PIN_STATUS:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Input path: a bypass is only safe for pure feed-through logic.
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            logic masked_in;
            assign masked_in = pin_in[g] & ~inbuf_dis_q[g];
            pin_sync u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .d       (masked_in),
                .q       (sync_pin[g])
            );
            assign in_sel[g] = in_sync_q[g] ? sync_pin[g] : masked_in;
            // Edges are taken from the synchronised copy only.
            pin_edge_detect u_edge (
                .pclk    (pclk),
                .presetn (presetn),
                .level   (sync_pin[g]),
                .mode    (edge_mode_t'(edge_q[2*g +: 2])),
                .event_q (pin_event[g])
            );
        end
    endgenerate

    // Fabric input bits are registered to keep every output on a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fabric_in  <= 8'h00;
            fabric_req <= 8'h00;
        end else begin
            fabric_in  <= in_sel;
            fabric_req <= in_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg_q <= 8'h00;
        end else begin
            out_reg_q <= fabric_out;
        end
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            out_sel[i] = out_pipe_q[i] ? out_reg_q[i] : fabric_out[i];
        end
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            case (oe_group)
                OE_GANG_ALL:  oe_vec[i] = fabric_oe[0];
                OE_GANG_TWO:  oe_vec[i] = fabric_oe[i/4];
                OE_GANG_FOUR: oe_vec[i] = fabric_oe[i/2];
                default:      oe_vec[i] = fabric_oe[0];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 8'h00;
            pin_oe  <= 8'h00;
        end else begin
            pin_out <= out_sel;
            pin_oe  <= oe_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad controls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvttl_sel <= THRESH_CMOS;
        end else begin
            lvttl_sel <= port_cfg_q[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inbuf_en <= 8'hff;
        end else begin
            inbuf_en <= ~inbuf_dis_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulated_sel <= 8'h00;
        end else begin
            regulated_sel <= special_q[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sel <= 8'h00;
        end else begin
            ref_sel <= special_q[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_mode <= 24'h00_0000;
        end else begin
            drive_mode <= drive_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration writes.
    // Every pin is unmasked out of reset; edge modes start at none.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 8'hff;
        end else if (wr_en && paddr == ADDR_INT_MASK) begin
            mask_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 16'h0000;
        end else if (wr_en && paddr == ADDR_EDGE_MODE) begin
            edge_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_cfg_q <= 3'h0;
        end else if (wr_en && paddr == ADDR_PORT_CFG) begin
            port_cfg_q <= pwdata[2:0];
        end
    end

    // Synchronisation starts enabled, since the processor may read pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sync_q <= RESET_SYNC[7:0];
        end else if (wr_en && paddr == ADDR_IN_SYNC) begin
            in_sync_q <= pwdata[7:0];
        end
    end

    // Pipelining costs one cycle of latency but removes fabric skew.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pipe_q <= 8'h00;
        end else if (wr_en && paddr == ADDR_OUT_PIPE) begin
            out_pipe_q <= pwdata[7:0];
        end
    end

    // A disabled buffer reads as low on every path, edges included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inbuf_dis_q <= 8'h00;
        end else if (wr_en && paddr == ADDR_INBUF_DIS) begin
            inbuf_dis_q <= pwdata[7:0];
        end
    end

    // Low byte selects regulated drive, high byte the pair references.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_q <= 16'h0000;
        end else if (wr_en && paddr == ADDR_SPECIAL_CFG) begin
            special_q <= pwdata[15:0];
        end
    end

    // Pulls are replaced by strong drive on regulated special pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= 24'h00_0000;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (wr_en && paddr == ADDR_DRIVE_MODE) begin
                    drive_q[3*i +: 3] <= pwdata[3*i +: 3];
                end
                if (special_q[i] &&
                    (drive_q[3*i +: 3] == DRIVE_PULL_UP ||
                     drive_q[3*i +: 3] == DRIVE_PULL_DOWN)) begin
                    drive_q[3*i +: 3] <= DRIVE_STRONG;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags run without any sleep gating of the clock path.
    // A read clears only the bits that it returned, so an event landing
    // between the setup and access edges of that read is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 8'h00;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (pin_event[i]) begin
                    status_q[i] <= 1'b1;
                end else if (rd_en && paddr == ADDR_INT_STATUS &&
                             prdata[i]) begin
                    status_q[i] <= 1'b0;
                end else if (wr_en && paddr == ADDR_INT_STATUS &&
                             pwdata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_irq <= 1'b0;
        end else begin
            port_irq <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answers in the access phase with no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RESET_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata  <= RESET_ZERO;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ADDR_INT_STATUS:  prdata[7:0]  <= status_q;
                    ADDR_INT_MASK:    prdata[7:0]  <= mask_q;
                    ADDR_EDGE_MODE:   prdata[15:0] <= edge_q;
                    ADDR_PORT_CFG:    prdata[2:0]  <= port_cfg_q;
                    ADDR_IN_SYNC:     prdata[7:0]  <= in_sync_q;
                    ADDR_OUT_PIPE:    prdata[7:0]  <= out_pipe_q;
                    ADDR_INBUF_DIS:   prdata[7:0]  <= inbuf_dis_q;
                    ADDR_SPECIAL_CFG: prdata[15:0] <= special_q;
                    ADDR_PIN_STATE:   prdata[7:0]  <= sync_pin;
                    ADDR_DRIVE_MODE:  prdata[23:0] <= drive_q;
                    ADDR_PIN_STATUS:  prdata[7:0]  <= status_q;
                    default:          prdata       <= RESET_ZERO;
                endcase
            end
        end
    end

endmodule : port_pin_interrupt_and_sync

// >>> tb/port_pin_properties.sv
`timescale 1ns/1ps
module port_pin_properties (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and fabric
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  fabric_out,
    input wire logic [7:0]  fabric_in,
    input wire logic [7:0]  fabric_req,
    // Pad controls and interrupt
    input wire logic        lvttl_sel,
    input wire logic [7:0]  inbuf_en,
    input wire logic [7:0]  regulated_sel,
    input wire logic [7:0]  ref_sel,
    input wire logic [23:0] drive_mode,
    input wire logic        port_irq
);
    logic [7:0] pull_bad;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A pull mode on a regulated pin may show for one cycle only.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pull_bad[i] = regulated_sel[i] && drive_mode[3*i+2 -: 2] == 2'h1;
        end
    end
    chk_pready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_answer_next: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    chk_slverr_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_irq_clear_cause: assert property ($fell(port_irq) |->
        $past(psel && penable, 1) || $past(psel && penable, 2))
        else $error("interrupt dropped without a bus access");
    chk_out_path: assert property (((pin_out ^ $past(fabric_out, 1)) &
        (pin_out ^ $past(fabric_out, 2))) == 8'h00)
        else $error("pin output not one or two cycles behind fabric");
    chk_in_path: assert property (((fabric_in ^ $past(pin_in, 1)) &
        (fabric_in ^ $past(pin_in, 3)) & inbuf_en & $past(inbuf_en, 1) &
        $past(inbuf_en, 2)) == 8'h00)
        else $error("fabric input not one or three cycles behind pin");
    chk_req_source: assert property (fabric_req == fabric_in)
        else $error("request sources differ from fabric data");
    chk_pull_regulated: assert property ((pull_bad & $past(pull_bad)) == 8'h00)
        else $error("pull mode kept on regulated pin");
    chk_cfg_written: assert property (
        $changed({lvttl_sel, inbuf_en, ref_sel, regulated_sel}) |->
        $past(psel && penable && pwrite, 2))
        else $error("pad control changed without a write");
    cov_irq: cover property ($rose(port_irq));
    cov_slverr: cover property (pslverr);
    cov_pull: cover property (pull_bad != 8'h00);
endmodule : port_pin_properties
////////////////////////////////////////////////////////////////////
bind port_pin_interrupt_and_sync port_pin_properties chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .fabric_out(fabric_out), .fabric_in(fabric_in),
    .fabric_req(fabric_req), .lvttl_sel(lvttl_sel), .inbuf_en(inbuf_en),
    .regulated_sel(regulated_sel), .ref_sel(ref_sel),
    .drive_mode(drive_mode), .port_irq(port_irq));

// >>> tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    // Clock
    input wire logic pclk,
    // Pins and interrupt controller side
    output logic [7:0] pin_in,
    input wire logic   port_irq
);
    int   irq_rises = 0;
    logic irq_seen  = 1'b0;
    initial pin_in = 8'h00;
    // Levels change just after an edge, as an external source would.
    task drive(input logic [7:0] v);
        pin_in <= v;
    endtask : drive
    // Counting rises tells one level request from repeated requests.
    always_ff @(posedge pclk) begin
        irq_seen <= port_irq;
        if (port_irq === 1'b1 && irq_seen === 1'b0) irq_rises <= irq_rises + 1;
    end
endmodule : pin_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    import port_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lvttl_sel;
    logic port_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0]  pin_in, pin_out, pin_oe, fabric_out, fabric_in, fabric_req;
    logic [7:0]  inbuf_en, regulated_sel, ref_sel;
    logic [3:0]  fabric_oe;
    logic [23:0] drive_mode;
    logic        e;
    int errors = 0;
    int comparisons = 0;
    pin_model pins (.pclk(pclk), .pin_in(pin_in), .port_irq(port_irq));
    port_pin_interrupt_and_sync dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .fabric_out(fabric_out), .fabric_oe(fabric_oe),
        .fabric_in(fabric_in), .fabric_req(fabric_req),
        .lvttl_sel(lvttl_sel), .inbuf_en(inbuf_en),
        .regulated_sel(regulated_sel), .ref_sel(ref_sel),
        .drive_mode(drive_mode), .port_irq(port_irq));
    ////////////////////////////////////////////////////////////////////
    task final_report;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    // Entered just after a rising edge; holds the request until pready,
    // then lets one idle edge pass so no strobe is driven twice at once.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; final_report(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, d, e);
    endtask : wr
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd
    task step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step
    ////////////////////////////////////////////////////////////////////
    task edge_scenario;
        wr(ADDR_EDGE_MODE, 32'h0000e4e4);
        rd(ADDR_INT_STATUS);
        pins.drive(8'hff); step(8);
        `CHECK(port_irq, 1'b1)
        rd(ADDR_INT_STATUS); `CHECK(d, 32'h000000aa)
        step(3); `CHECK(port_irq, 1'b0)
        step(8); rd(ADDR_PIN_STATUS); `CHECK(d, 32'h00000000)
        pins.drive(8'h00); step(8);
        rd(ADDR_PIN_STATUS); `CHECK(d, 32'h000000cc)
        `CHECK(pins.irq_rises, 2)
    endtask : edge_scenario
    task mask_scenario;
        wr(ADDR_INT_MASK, 32'h0); pins.drive(8'hff); step(8);
        `CHECK(port_irq, 1'b0)
        wr(ADDR_INT_MASK, 32'hff); step(3); `CHECK(port_irq, 1'b1)
        wr(ADDR_INT_STATUS, 32'hff); step(3); `CHECK(port_irq, 1'b0)
        pins.drive(8'h00); step(8); rd(ADDR_INT_STATUS);
        wr(ADDR_INT_STATUS, 32'hff); // Acts as a second, harmless clear.
    endtask : mask_scenario
    task path_scenario;
        wr(ADDR_IN_SYNC, 32'h0); wr(ADDR_OUT_PIPE, 32'h0);
        pins.drive(8'h5a); fabric_out <= 8'h3c; @(posedge pclk); @(negedge pclk);
        `CHECK(fabric_in, 8'h5a)
        `CHECK(pin_out, 8'h3c)
        `CHECK(fabric_req, 8'h5a)
        @(posedge pclk);
        wr(ADDR_IN_SYNC, 32'hff); wr(ADDR_OUT_PIPE, 32'hff);
        pins.drive(8'ha5); fabric_out <= ~fabric_out; @(posedge pclk); @(negedge pclk);
        `CHECK(pin_out, 8'h3c)
        @(posedge pclk); @(negedge pclk); `CHECK(pin_out, 8'hc3)
        `CHECK(fabric_in, 8'h5a)
        @(posedge pclk); @(negedge pclk); `CHECK(fabric_in, 8'ha5)
        @(posedge pclk);
    endtask : path_scenario
    task pad_scenario;
        logic [3:0] oe_tab [3];
        logic [7:0] exp_tab [3];
        oe_tab = '{4'h1, 4'h2, 4'h5};
        exp_tab = '{8'hff, 8'hf0, 8'h33};
        wr(ADDR_PORT_CFG, 32'h1); wr(ADDR_INBUF_DIS, 32'h0f);
        wr(ADDR_SPECIAL_CFG, 32'h0000e401); wr(ADDR_DRIVE_MODE, 32'h1a); step(3);
        `CHECK(lvttl_sel, 1'b1)
        `CHECK(inbuf_en, 8'hf0)
        `CHECK(regulated_sel, 8'h01)
        `CHECK(ref_sel, 8'he4)
        `CHECK(drive_mode, 24'h00001e)
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_PORT_CFG, 32'(k) << 1); fabric_oe <= oe_tab[k]; step(3);
            `CHECK(pin_oe, exp_tab[k])
        end
        apb(1'b0, 12'h100, 32'h0, d, e);
        `CHECK(e, 1'b1)
        `CHECK(d, 32'h0)
    endtask : pad_scenario
    ////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; fabric_out = 8'h00; fabric_oe = 4'h0;
        step(2);
        presetn <= 1'b1;
        step(1);
        `CHECK(inbuf_en, 8'hff)
        rd(ADDR_INT_MASK); `CHECK(d, 32'h000000ff)
        rd(ADDR_IN_SYNC); `CHECK(d, 32'h000000ff)
        edge_scenario();
        mask_scenario();
        path_scenario();
        pad_scenario();
        final_report();
    end
endmodule : tb
